// ==== hw/gosc_pkg.sv ====
// constants and types shared by the gpio output set/clear block
package gosc_pkg;

    // ------------------------------------------------------------
    // kinds of latch update
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        GOSC_ACC_NONE = 2'b00,
        GOSC_ACC_SET  = 2'b01,
        GOSC_ACC_CLR  = 2'b10
    } gosc_access_t;

    // ------------------------------------------------------------
    // fast view word and byte addresses (byte and half registers share the word decode)
    // ------------------------------------------------------------
    localparam logic [31:0] GOSC_F0_MASK     = 32'h3FFF_C010;
    localparam logic [31:0] GOSC_F0_SET      = 32'h3FFF_C018;
    localparam logic [31:0] GOSC_F0_SET_B1   = 32'h3FFF_C019;
    localparam logic [31:0] GOSC_F0_SET_B2   = 32'h3FFF_C01A;
    localparam logic [31:0] GOSC_F0_SET_B3   = 32'h3FFF_C01B;
    localparam logic [31:0] GOSC_F0_CLR      = 32'h3FFF_C01C;
    localparam logic [31:0] GOSC_F1_MASK     = 32'h3FFF_C030;
    localparam logic [31:0] GOSC_F1_SET      = 32'h3FFF_C038;
    localparam logic [31:0] GOSC_F1_SET_B1   = 32'h3FFF_C039;
    localparam logic [31:0] GOSC_F1_SET_B2   = 32'h3FFF_C03A;
    localparam logic [31:0] GOSC_F1_SET_B3   = 32'h3FFF_C03B;
    localparam logic [31:0] GOSC_F1_CLR      = 32'h3FFF_C03C;

    // ------------------------------------------------------------
    // legacy view word addresses
    // ------------------------------------------------------------
    localparam logic [31:0] GOSC_L0_SET      = 32'hE002_8004;
    localparam logic [31:0] GOSC_L0_DIR      = 32'hE002_8008;
    localparam logic [31:0] GOSC_L0_CLR      = 32'hE002_800C;
    localparam logic [31:0] GOSC_L1_SET      = 32'hE002_8014;
    localparam logic [31:0] GOSC_L1_DIR      = 32'hE002_8018;
    localparam logic [31:0] GOSC_L1_CLR      = 32'hE002_801C;

    // ------------------------------------------------------------
    // reset values and byte-lane patterns
    // ------------------------------------------------------------
    localparam logic [31:0] GOSC_OUT_RST     = 32'h0000_0000;
    localparam logic [31:0] GOSC_MASK_RST    = 32'h0000_0000;
    localparam logic [31:0] GOSC_DIR_RST     = 32'h0000_0000;
    localparam logic [31:0] GOSC_ZERO        = 32'h0000_0000;
    localparam logic [31:0] GOSC_ONES        = 32'hFFFF_FFFF;
    localparam logic [31:0] GOSC_LANE1_BITS  = 32'h0000_FF00;
    localparam logic [3:0]  GOSC_STRB_WORD   = 4'hF;
    localparam logic [3:0]  GOSC_STRB_HALF_L = 4'h3;
    localparam logic [3:0]  GOSC_STRB_HALF_U = 4'hC;
    localparam logic [3:0]  GOSC_STRB_B0     = 4'h1;
    localparam logic [3:0]  GOSC_STRB_B1     = 4'h2;
    localparam logic [3:0]  GOSC_STRB_B2     = 4'h4;
    localparam logic [3:0]  GOSC_STRB_B3     = 4'h8;
    localparam int          GOSC_LANES       = 4;
    localparam int          GOSC_LANE_W      = 8;
    localparam int          GOSC_PORTS       = 2;

endpackage

// ==== hw/gosc_out_latch.sv ====
// output latch of one gpio port with set/clear and fast mask gating
`timescale 1ns/100ps
module gosc_out_latch (
    input  wire logic                  ref_clk,
    input  wire logic                  srst,
    input  wire gosc_pkg::gosc_access_t wr_kind,
    input  wire logic                  wr_fast,
    input  wire logic [31:0]           wr_bits,
    input  wire logic [31:0]           fast_mask,
    input  wire logic [31:0]           pin_out_en,
    output logic      [31:0]           latch
);

    // ------------------------------------------------------------
    // bits a write may touch
    // ------------------------------------------------------------
    logic [31:0] effect;
    logic [31:0] next_latch;

    // only output pins, and on the fast view only unmasked ones
    assign effect = wr_bits & pin_out_en                      // see [R3]
                  & (wr_fast ? ~fast_mask : gosc_pkg::GOSC_ONES); // see [R20] see [R21]

    // set ors ones in, clear knocks them out, zeros keep
    always_comb begin
        next_latch = latch;
        if (wr_kind == gosc_pkg::GOSC_ACC_SET) begin
            next_latch = latch | effect;        // see [R18]
        end else if (wr_kind == gosc_pkg::GOSC_ACC_CLR) begin
            next_latch = latch & ~effect;       // see [R1] see [R2]
        end
    end

    // latch holds both the pin level and the set readback
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            latch <= gosc_pkg::GOSC_OUT_RST;
        end else begin
            latch <= next_latch;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_set_drives_high: assert property (@(posedge ref_clk) disable iff (srst) // see [R18]
        wr_kind == gosc_pkg::GOSC_ACC_SET |=> (latch & $past(effect)) == $past(effect))
        else $error("set write did not raise its pins");
    chk_clear_drives_low: assert property (@(posedge ref_clk) disable iff (srst) // see [R1]
        wr_kind == gosc_pkg::GOSC_ACC_CLR |=> (latch & $past(effect)) == gosc_pkg::GOSC_ZERO)
        else $error("clear write did not lower its pins");
    chk_untouched_bits_keep: assert property (@(posedge ref_clk) disable iff (srst) // see [R2]
        1'b1 |=> ((latch ^ $past(latch)) & ~$past(effect)) == gosc_pkg::GOSC_ZERO)
        else $error("latch bit changed without a written one");
    chk_input_pins_keep: assert property (@(posedge ref_clk) disable iff (srst) // see [R3]
        1'b1 |=> ((latch ^ $past(latch)) & ~$past(pin_out_en)) == gosc_pkg::GOSC_ZERO)
        else $error("input or secondary pin latch changed");
    chk_masked_bits_keep: assert property (@(posedge ref_clk) disable iff (srst) // see [R21]
        wr_fast |=> ((latch ^ $past(latch)) & $past(fast_mask)) == gosc_pkg::GOSC_ZERO)
        else $error("masked pin changed by a fast write");

endmodule

// ==== hw/gosc_top.sv ====
// apb register block for gpio output set/clear on two 32-bit ports
//
// How it works
// [R1] a one written to clear drives the output pin low and clears the set bit
// [R2] zero bits in a clear write leave pin and set bit unchanged
// [R3] clear writes do nothing to input or secondary-function pins
// [R4] fast set writes only touch pins their own port's mask allows
// [R5] fast clear writes are gated by their own port's mask too
// [R6] legacy port 0 set register, word wide, bit n is pin n, resets zero
// [R7] legacy port 1 set register, word wide, bit n is pin n, resets zero
// [R8] fast port 0 set register, word wide, bit n is pin n, resets zero
// [R9] fast port 1 set register, word wide, bit n is pin n, resets zero
// [R10] fast word set is word access; byte and half views do the same set
// [R11] port 0 byte set registers: byte k covers pins 8k to 8k+7
// [R12] port 0 low and high half set registers cover pins 0-15 and 16-31
// [R13] port 1 byte set registers: byte k covers pins 8k to 8k+7
// [R14] port 1 low and high half set registers cover pins 0-15 and 16-31
// [R15] legacy port 0 clear register, word wide, resets zero
// [R16] legacy port 1 clear register, word wide, resets zero
// [R17] fast port 0 clear register, word wide, resets zero
// [R18] a one written to set drives output pins high; zeros and inputs untouched
// [R19] reading set returns the stored output latch, not the pin level
// [R20] fast accesses act only on pins whose mask bit is zero
// [R21] masked pins ignore ones written through fast set or clear
`timescale 1ns/100ps
module gosc_top (
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [31:0] gpio0_func_sel,
    input  wire logic [31:0] gpio1_func_sel,
    output logic      [31:0] gpio0_out,
    output logic      [31:0] gpio0_oe,
    output logic      [31:0] gpio1_out,
    output logic      [31:0] gpio1_oe
);

    // ------------------------------------------------------------
    // storage and decode signals
    // ------------------------------------------------------------
    logic [31:0]            dir_q     [gosc_pkg::GOSC_PORTS];
    logic [31:0]            mask_q    [gosc_pkg::GOSC_PORTS];
    logic [31:0]            latch     [gosc_pkg::GOSC_PORTS];
    logic [31:0]            func_sel  [gosc_pkg::GOSC_PORTS];
    logic [31:0]            out_en    [gosc_pkg::GOSC_PORTS];
    gosc_pkg::gosc_access_t port_kind [gosc_pkg::GOSC_PORTS];
    logic [31:0]            addr_word;
    logic [31:0]            lane_bits;
    logic [31:0]            wr_bits;
    logic                   dec_hit;
    logic                   dec_port;
    logic                   dec_fast;
    logic                   dec_mask;
    logic                   dec_dir;
    gosc_pkg::gosc_access_t dec_kind;
    logic                   strb_fast_ok;
    logic                   strb_word_ok;
    logic                   dec_err;
    logic                   setup_ph;
    logic                   wr_ok;
    logic [31:0]            next_rdata;
    logic                   err_q;

    // ------------------------------------------------------------
    // apb phases
    // ------------------------------------------------------------
    // zero wait states: every access phase completes at once
    assign pready    = 1'b1;
    assign setup_ph  = psel & ~penable;
    assign addr_word = {paddr[31:2], 2'b00};
    assign pslverr   = err_q & psel & penable;
    // a write lands at the single edge that completes the access
    assign wr_ok     = psel & penable & pwrite & ~dec_err;

    // ------------------------------------------------------------
    // byte lanes
    // ------------------------------------------------------------
    // one byte of bit enables per strobe
    genvar k;
    generate
        for (k = 0; k < gosc_pkg::GOSC_LANES; k++) begin : g_lane
            assign lane_bits[k*gosc_pkg::GOSC_LANE_W +: gosc_pkg::GOSC_LANE_W] =
                {gosc_pkg::GOSC_LANE_W{pstrb[k]}}; // see [R11] see [R13]
        end
    endgenerate

    // sub-word views hit only their own pins
    assign wr_bits = pwdata & lane_bits;   // see [R10] see [R12] see [R14]

    // byte, half or word strobes are legal on the fast view
    always_comb begin
        unique case (pstrb)
            gosc_pkg::GOSC_STRB_B0,
            gosc_pkg::GOSC_STRB_B1,
            gosc_pkg::GOSC_STRB_B2,
            gosc_pkg::GOSC_STRB_B3,
            gosc_pkg::GOSC_STRB_HALF_L,
            gosc_pkg::GOSC_STRB_HALF_U,
            gosc_pkg::GOSC_STRB_WORD: strb_fast_ok = 1'b1;
            default:                  strb_fast_ok = 1'b0;
        endcase
    end

    // legacy view takes whole words only
    assign strb_word_ok = (pstrb == gosc_pkg::GOSC_STRB_WORD);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    // map the word address to port, view and register kind
    always_comb begin
        dec_hit  = 1'b1;
        dec_port = 1'b0;
        dec_fast = 1'b0;
        dec_mask = 1'b0;
        dec_dir  = 1'b0;
        dec_kind = gosc_pkg::GOSC_ACC_NONE;
        case (addr_word)
            gosc_pkg::GOSC_F0_MASK: begin
                dec_fast = 1'b1;
                dec_mask = 1'b1;
            end
            gosc_pkg::GOSC_F0_SET: begin
                dec_fast = 1'b1;
                dec_kind = gosc_pkg::GOSC_ACC_SET;     // see [R8] see [R11] see [R12]
            end
            gosc_pkg::GOSC_F0_CLR: begin
                dec_fast = 1'b1;
                dec_kind = gosc_pkg::GOSC_ACC_CLR;     // see [R17]
            end
            gosc_pkg::GOSC_F1_MASK: begin
                dec_port = 1'b1;
                dec_fast = 1'b1;
                dec_mask = 1'b1;
            end
            gosc_pkg::GOSC_F1_SET: begin
                dec_port = 1'b1;
                dec_fast = 1'b1;
                dec_kind = gosc_pkg::GOSC_ACC_SET;     // see [R9] see [R13] see [R14]
            end
            gosc_pkg::GOSC_F1_CLR: begin
                dec_port = 1'b1;
                dec_fast = 1'b1;
                dec_kind = gosc_pkg::GOSC_ACC_CLR;
            end
            gosc_pkg::GOSC_L0_SET: begin
                dec_kind = gosc_pkg::GOSC_ACC_SET;     // see [R6]
            end
            gosc_pkg::GOSC_L0_DIR: begin
                dec_dir  = 1'b1;
            end
            gosc_pkg::GOSC_L0_CLR: begin
                dec_kind = gosc_pkg::GOSC_ACC_CLR;     // see [R15]
            end
            gosc_pkg::GOSC_L1_SET: begin
                dec_port = 1'b1;
                dec_kind = gosc_pkg::GOSC_ACC_SET;     // see [R7]
            end
            gosc_pkg::GOSC_L1_DIR: begin
                dec_port = 1'b1;
                dec_dir  = 1'b1;
            end
            gosc_pkg::GOSC_L1_CLR: begin
                dec_port = 1'b1;
                dec_kind = gosc_pkg::GOSC_ACC_CLR;     // see [R16]
            end
            default: begin
                dec_hit  = 1'b0;
            end
        endcase
    end

    // unmapped address, or bad strobes on a write, is refused
    assign dec_err = ~dec_hit
                   | (pwrite & (dec_fast ? ~strb_fast_ok : ~strb_word_ok)); // see [R10]

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    // set reads the latch; clear registers read as zero
    always_comb begin
        next_rdata = gosc_pkg::GOSC_ZERO;
        if (!dec_err) begin
            if (dec_mask) begin
                next_rdata = mask_q[dec_port];
            end else if (dec_dir) begin
                next_rdata = dir_q[dec_port];
            end else if (dec_kind == gosc_pkg::GOSC_ACC_SET) begin
                next_rdata = latch[dec_port];          // see [R19]
            end
        end
    end

    // read data and error captured in the setup phase
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            prdata <= gosc_pkg::GOSC_ZERO;
            err_q  <= 1'b0;
        end else if (setup_ph) begin
            prdata <= pwrite ? gosc_pkg::GOSC_ZERO : next_rdata;
            err_q  <= dec_err;
        end
    end

    // ------------------------------------------------------------
    // per-port control and output latch
    // ------------------------------------------------------------
    assign func_sel[0] = gpio0_func_sel;
    assign func_sel[1] = gpio1_func_sel;

    genvar p;
    generate
        for (p = 0; p < gosc_pkg::GOSC_PORTS; p++) begin : g_port
            // direction register, word writes on the legacy view
            always_ff @(posedge ref_clk) begin
                if (srst) begin
                    dir_q[p] <= gosc_pkg::GOSC_DIR_RST;
                end else if (wr_ok && dec_dir && (dec_port == 1'(p))) begin
                    dir_q[p] <= pwdata;
                end
            end

            // fast mask register, byte lanes merged in
            always_ff @(posedge ref_clk) begin
                if (srst) begin
                    mask_q[p] <= gosc_pkg::GOSC_MASK_RST;
                end else if (wr_ok && dec_mask && (dec_port == 1'(p))) begin
                    mask_q[p] <= (mask_q[p] & ~lane_bits) | wr_bits;
                end
            end

            // gpio output pins, not handed to a secondary function
            assign out_en[p] = dir_q[p] & ~func_sel[p];  // see [R3]

            // set or clear request for this port only
            assign port_kind[p] = (wr_ok && (dec_port == 1'(p)))
                                ? dec_kind : gosc_pkg::GOSC_ACC_NONE;

            gosc_out_latch u_latch (
                .ref_clk    (ref_clk),
                .srst       (srst),
                .wr_kind    (port_kind[p]),
                .wr_fast    (dec_fast),              // see [R4] see [R5]
                .wr_bits    (wr_bits),
                .fast_mask  (mask_q[p]),
                .pin_out_en (out_en[p]),
                .latch      (latch[p])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    assign gpio0_out = latch[0];
    assign gpio1_out = latch[1];
    assign gpio0_oe  = out_en[0];
    assign gpio1_oe  = out_en[1];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // reset empties both output latches
    chk_reset_clears_out: assert property (@(posedge ref_clk) // see [R6] see [R7]
        srst |=> (gpio0_out == gosc_pkg::GOSC_OUT_RST) && (gpio1_out == gosc_pkg::GOSC_OUT_RST))
        else $error("outputs not zero after reset");

    // set reads show the latch, not the pins
    chk_set_readback: assert property (@(posedge ref_clk) disable iff (srst) // see [R19]
        psel && penable && !pwrite && !pslverr && (addr_word == gosc_pkg::GOSC_L1_SET)
        |-> prdata == gpio1_out)
        else $error("set readback differs from latch");

    // a byte write stays inside its lane
    chk_byte_lane_only: assert property (@(posedge ref_clk) disable iff (srst) // see [R11]
        psel && penable && pwrite && (addr_word == gosc_pkg::GOSC_F0_SET)
        && (pstrb == gosc_pkg::GOSC_STRB_B1)
        |=> ((gpio0_out ^ $past(gpio0_out)) & ~gosc_pkg::GOSC_LANE1_BITS) == gosc_pkg::GOSC_ZERO)
        else $error("byte set changed pins outside its lane");

    // legacy views refuse partial words
    chk_legacy_word_only: assert property (@(posedge ref_clk) disable iff (srst) // see [R10]
        setup_ph && pwrite && (addr_word == gosc_pkg::GOSC_L0_CLR) && !strb_word_ok
        ##1 psel && penable |-> pslverr ##1 $stable(gpio0_out))
        else $error("partial legacy write not refused");

    // port 0 clear leaves port 1 alone
    chk_port_isolation: assert property (@(posedge ref_clk) disable iff (srst) // see [R4]
        psel && penable && pwrite && (addr_word == gosc_pkg::GOSC_F0_CLR)
        |=> $stable(gpio1_out))
        else $error("port 0 write changed port 1");

    // a refused write leaves both ports as they were
    chk_refused_keeps: assert property (@(posedge ref_clk) disable iff (srst) // see [R10]
        psel && penable && pwrite && pslverr
        |=> $stable(gpio0_out) && $stable(gpio1_out))
        else $error("refused write changed an output");

    // masked port 1 pins survive a fast set
    chk_port1_mask_gates: assert property (@(posedge ref_clk) disable iff (srst) // see [R4]
        psel && penable && pwrite && !pslverr && (addr_word == gosc_pkg::GOSC_F1_SET)
        |=> ((gpio1_out ^ $past(gpio1_out)) & $past(mask_q[1])) == gosc_pkg::GOSC_ZERO)
        else $error("fast set changed a masked port 1 pin");

    // masked port 0 pins survive a fast clear
    chk_fast_clr_masked: assert property (@(posedge ref_clk) disable iff (srst) // see [R5]
        psel && penable && pwrite && !pslverr && (addr_word == gosc_pkg::GOSC_F0_CLR)
        |=> ((gpio0_out ^ $past(gpio0_out)) & $past(mask_q[0])) == gosc_pkg::GOSC_ZERO)
        else $error("fast clear changed a masked port 0 pin");

    // a legacy set raises every written output pin
    chk_legacy_set_high: assert property (@(posedge ref_clk) disable iff (srst) // see [R7]
        psel && penable && pwrite && !pslverr && (addr_word == gosc_pkg::GOSC_L1_SET)
        |=> (gpio1_out & $past(pwdata & gpio1_oe)) == $past(pwdata & gpio1_oe))
        else $error("legacy set missed a port 1 pin");

    // reset also quiets read data, error and drive enables
    chk_reset_quiet_bus: assert property (@(posedge ref_clk) // see [R6]
        srst |=> (prdata == gosc_pkg::GOSC_ZERO) && !pslverr
                 && (gpio0_oe == gosc_pkg::GOSC_ZERO) && (gpio1_oe == gosc_pkg::GOSC_ZERO))
        else $error("bus or enables not quiet after reset");

    // main scenarios worth seeing
    cov_fast_byte_set: cover property (@(posedge ref_clk) disable iff (srst)
        wr_ok && dec_fast && (dec_kind == gosc_pkg::GOSC_ACC_SET)
        && (pstrb == gosc_pkg::GOSC_STRB_B2));
    cov_legacy_clear: cover property (@(posedge ref_clk) disable iff (srst)
        wr_ok && !dec_fast && (dec_kind == gosc_pkg::GOSC_ACC_CLR) && (gpio0_out != 32'h0));
    cov_masked_write: cover property (@(posedge ref_clk) disable iff (srst)
        wr_ok && dec_fast && ((wr_bits & mask_q[1]) != 32'h0));
    cov_slave_error: cover property (@(posedge ref_clk) disable iff (srst)
        pslverr);
    cov_port1_half_set: cover property (@(posedge ref_clk) disable iff (srst)
        wr_ok && dec_fast && dec_port && (pstrb == gosc_pkg::GOSC_STRB_HALF_U));

endmodule

// ==== tb/gpio_output_set_clear_bench.sv ====
// self-checking bench for the gpio output set/clear register block
`timescale 1ns/100ps
module gpio_output_set_clear_bench;
    logic        ref_clk = 1'b0;
    logic        srst    = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [31:0] paddr   = 32'h0000_0000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [3:0]  pstrb   = 4'h0;
    logic [31:0] func0   = 32'h0000_0000;
    logic [31:0] func1   = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] out0;
    logic [31:0] oe0;
    logic [31:0] out1;
    logic [31:0] oe1;
    logic [31:0] rdat;
    logic        rerr;
    logic [3:0]  strb [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC};
    int          errors  = 0;
    int          n_checks = 0;

    gosc_top gosc_top_inst (
        .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .gpio0_func_sel(func0), .gpio1_func_sel(func1),
        .gpio0_out(out0), .gpio0_oe(oe0), .gpio1_out(out1), .gpio1_oe(oe1)
    );

    // 25 MHz clock
    always #20 ref_clk = ~ref_clk;

    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer, held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d, gosc_pkg::GOSC_STRB_WORD);
    endtask

    task automatic rdc(input string what, input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000, gosc_pkg::GOSC_STRB_WORD);
        chk(what, exp, rdat);
    endtask

    // byte lane k of the strobe covers pins 8k to 8k+7
    function automatic logic [31:0] lanes(input logic [3:0] s);
        for (int k = 0; k < 4; k++) lanes[8*k +: 8] = {8{s[k]}};
    endfunction

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rdc("l0 set", gosc_pkg::GOSC_L0_SET, 32'h0000_0000);
        rdc("l1 set", gosc_pkg::GOSC_L1_SET, 32'h0000_0000);
        rdc("f0 set", gosc_pkg::GOSC_F0_SET, 32'h0000_0000);
        rdc("f1 set", gosc_pkg::GOSC_F1_SET, 32'h0000_0000);
        rdc("l0 clr", gosc_pkg::GOSC_L0_CLR, 32'h0000_0000);
        rdc("l1 clr", gosc_pkg::GOSC_L1_CLR, 32'h0000_0000);
        rdc("f0 clr", gosc_pkg::GOSC_F0_CLR, 32'h0000_0000);
        chk("out0", 32'h0000_0000, out0);
        $display("test reset done");
    endtask

    task automatic t_legacy();
        func0 <= 32'h0000_00F0;
        wr(gosc_pkg::GOSC_L0_DIR, 32'h0000_FFFF);
        chk("oe0", 32'h0000_FF0F, oe0);
        wr(gosc_pkg::GOSC_L0_SET, 32'hFFFF_FFFF);
        chk("out0 set", 32'h0000_FF0F, out0);
        wr(gosc_pkg::GOSC_L0_CLR, 32'h0000_0F03);
        chk("out0 clr", 32'h0000_F00C, out0);
        rdc("l0 set back", gosc_pkg::GOSC_L0_SET, 32'h0000_F00C);
        func0 <= 32'h0000_F000;
        wr(gosc_pkg::GOSC_L0_CLR, 32'hFFFF_FFFF);
        chk("out0 clr func", 32'h0000_F000, out0);
        func1 <= 32'h0000_000F;
        wr(gosc_pkg::GOSC_L1_DIR, 32'hFFFF_FFFF);
        chk("oe1", 32'hFFFF_FFF0, oe1);
        wr(gosc_pkg::GOSC_L1_SET, 32'hA5A5_A5A5);
        chk("out1 set", 32'hA5A5_A5A0, out1);
        wr(gosc_pkg::GOSC_L1_CLR, 32'h0000_00A5);
        chk("out1", 32'hA5A5_A500, out1);
        $display("test legacy done");
    endtask

    task automatic t_mask();
        func0 <= 32'h0000_0000;
        func1 <= 32'h0000_0000;
        wr(gosc_pkg::GOSC_F0_MASK, 32'h0000_00FF);
        wr(gosc_pkg::GOSC_F0_SET, 32'hFFFF_FFFF);
        chk("f0 set masked", 32'h0000_FF00 | 32'h0000_F000, out0);
        wr(gosc_pkg::GOSC_L0_SET, 32'h0000_00FF);
        wr(gosc_pkg::GOSC_F0_CLR, 32'hFFFF_FFFF);
        chk("f0 clr masked", 32'h0000_00FF, out0);
        wr(gosc_pkg::GOSC_F1_MASK, 32'hFFFF_0000);
        wr(gosc_pkg::GOSC_F1_CLR, 32'hFFFF_FFFF);
        chk("f1 clr masked", 32'hA5A5_0000, out1);
        wr(gosc_pkg::GOSC_F1_SET, 32'hFFFF_FFFF);
        chk("f1 set masked", 32'hA5A5_FFFF, out1);
        $display("test mask done");
    endtask

    task automatic t_lanes();
        wr(gosc_pkg::GOSC_F0_MASK, 32'h0000_0000);
        wr(gosc_pkg::GOSC_F1_MASK, 32'h0000_0000);
        wr(gosc_pkg::GOSC_L0_DIR, 32'hFFFF_FFFF);
        for (int i = 0; i < 6; i++) begin
            wr(gosc_pkg::GOSC_L0_CLR, 32'hFFFF_FFFF);
            wr(gosc_pkg::GOSC_L1_CLR, 32'hFFFF_FFFF);
            apb(1'b1, gosc_pkg::GOSC_F0_SET, 32'hFFFF_FFFF, strb[i]);
            apb(1'b1, gosc_pkg::GOSC_F1_SET, 32'hFFFF_FFFF, strb[i]);
            chk("f0 lanes", lanes(strb[i]), out0);
            chk("f1 lanes", lanes(strb[i]), out1);
            rdc("f1 set read", gosc_pkg::GOSC_F1_SET, lanes(strb[i]));
        end
        $display("test lanes done");
    endtask

    task automatic t_refuse();
        wr(32'h0000_0100, 32'hFFFF_FFFF);
        chk("unmapped err", 32'h0000_0001, 32'(rerr));
        apb(1'b1, gosc_pkg::GOSC_L0_CLR, 32'hFFFF_FFFF, 4'h3);
        chk("legacy strobe err", 32'h0000_0001, 32'(rerr));
        apb(1'b1, gosc_pkg::GOSC_F1_SET, 32'hFFFF_FFFF, 4'h5);
        chk("fast strobe err", 32'h0000_0001, 32'(rerr));
        chk("out0 kept", 32'hFFFF_0000, out0);
        chk("out1 kept", 32'hFFFF_0000, out1);
        wr(gosc_pkg::GOSC_L0_SET, 32'h0000_0001);
        chk("good err", 32'h0000_0000, 32'(rerr));
        chk("out0 one", 32'hFFFF_0001, out0);
        $display("test refuse done");
    endtask

    // ------------------------------------------------------------
    // verdict and main sequence
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        errors++;
        stop_test();
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        srst <= 1'b0;
        t_reset();
        t_legacy();
        t_mask();
        t_lanes();
        t_refuse();
        stop_test();
    end
endmodule
